// file: logic/icm_pkg.sv
// Shared constants and encodings for the IQ carrier slot mapper
package icm_pkg;
    // Basic frame geometry
    localparam int ICM_WORDS_PER_BF = 16;                // Words in one basic frame
    localparam logic [3:0] ICM_CTRL_WORD = 4'h0;         // Word index of the control word
    localparam logic [3:0] ICM_LAST_WORD = 4'hf;         // Last IQ word
    // Field widths
    localparam int ICM_SMP_W = 20;                       // Widest I or Q sample
    localparam int ICM_MW_W = 5;                         // Sample width field
    localparam int ICM_SK_W = 16;                        // S and K fields
    localparam int ICM_SLOT_W = 12;                      // Slot width and bit positions
    localparam int ICM_BLK_W = 28;                       // Bit counts inside a slot block
    localparam int ICM_SYM_W = 8;                        // Symbols per frame
    localparam int ICM_BIT_W = 7;                        // Bit index inside a word
    // Sample width limits per direction
    localparam logic [4:0] ICM_DL_MIN_W = 5'h08;         // Downlink least width
    localparam logic [4:0] ICM_UL_MIN_W = 5'h04;         // Uplink least width
    localparam logic [4:0] ICM_MAX_W = 5'h14;            // Largest width, both directions
    // Oversampling choices for the chip-rate standard
    localparam logic [2:0] ICM_UL_OVS_A = 3'h2;
    localparam logic [2:0] ICM_UL_OVS_B = 3'h4;
    localparam logic [2:0] ICM_DL_OVS_A = 3'h1;
    localparam logic [2:0] ICM_DL_OVS_B = 3'h2;
    // Reset values
    localparam logic [ICM_BLK_W-1:0] ICM_RST_CNT = 28'h0000000;
    localparam logic [ICM_SMP_W-1:0] ICM_RST_SMP = 20'h00000;
    // Radio standard of a carrier
    typedef enum logic [1:0] {
        ICM_STD_CHIP = 2'b00,                            // chip_rate_standard
        ICM_STD_OFDM = 2'b01,                            // ofdm_cellular_standard
        ICM_STD_SYMF = 2'b10                             // Symbol-frame standard
    } icm_std_t;
    // Mapping method of a carrier
    typedef enum logic [1:0] {
        ICM_METH_CHIP = 2'b00,                           // n samples per slot
        ICM_METH_SMP = 2'b01,                            // Method 1, sample based
        ICM_METH_SYM = 2'b10,                            // Method 2, symbol based
        ICM_METH_BC = 2'b11                              // Method 3, one sample per slot
    } icm_meth_t;
endpackage : icm_pkg

// file: logic/icm_mapper.sv
// Carrier slot mapper: places antenna_carrier IQ samples into the IQ data block of each basic frame
// Summary of operation
// R1: Slot width must be even.
// R2: Samples chronological, I/Q interleaved, LSB first.
// R3: Chip-rate slot holds n samples, one carrier.
// R4: Uplink oversampling is 2 or 4.
// R5: Downlink oversampling is 1 or 2.
// R6: Directions configured independently per carrier.
// R7: Slots contiguous, never overlapping.
// R8: Packed slots back to back, ascending carrier.
// R9: Flexible slot starts at word>0, even bit.
// R10: Uncovered IQ bits are reserved bits.
// R11: Slot blocks of K frames form continuous stream.
// R12: S and K nonzero, chosen per carrier.
// R13: Method 1 slot width is 2*ceil(M*S/K).
// R14: Method 1 K and S from rate LCM.
// R15: Method 1 block starts with stuffing, then samples.
// R16: Each direction uses its own sample width.
// R17: Method 2 block aligns to radio frame.
// R18: Method 2: symbol blocks, then frame stuffing.
// R19: Symbol block: samples then stuffing; S=Nsym*Nsam.
// R20: Method 2 slot at least 2*ceil(M*S/K).
// R21: Symbol stuffing floor-divided, frame stuffing remainder.
// R22: OFDM uses method 1/3; symbol-frame 1/2/3.
// R23: Width 8..20 downlink, 4..20 uplink.
// R24: Sixteen words; word 0 control, rest IQ.
// R25: Per-carrier configuration loaded only while idle.
module icm_mapper
    import icm_pkg::*;
#(
    parameter int NUM_AC = 4,                            // Antenna carriers handled
    parameter int WORD_BITS = 32                         // Word length for the line rate
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Framing
    input wire logic i_bit_en,
    input wire logic i_bf_start,
    input wire logic i_radio_frame,
    input wire logic i_packed,
    // Per carrier configuration
    input wire logic [NUM_AC-1:0] i_ac_en,
    input wire logic [NUM_AC-1:0] i_cfg_load,
    input wire logic [NUM_AC-1:0] i_cfg_ul,
    input wire logic [NUM_AC-1:0][1:0] i_cfg_std,
    input wire logic [NUM_AC-1:0][1:0] i_cfg_method,
    input wire logic [NUM_AC-1:0][ICM_MW_W-1:0] i_cfg_width,
    input wire logic [NUM_AC-1:0][2:0] i_cfg_ovs,
    input wire logic [NUM_AC-1:0][ICM_SK_W-1:0] i_cfg_s,
    input wire logic [NUM_AC-1:0][ICM_SK_W-1:0] i_cfg_k,
    input wire logic [NUM_AC-1:0][ICM_SLOT_W-1:0] i_cfg_slot,
    input wire logic [NUM_AC-1:0][3:0] i_cfg_word,
    input wire logic [NUM_AC-1:0][ICM_BIT_W-1:0] i_cfg_bit,
    input wire logic [NUM_AC-1:0][ICM_SYM_W-1:0] i_cfg_nsym,
    input wire logic [NUM_AC-1:0][ICM_SLOT_W-1:0] i_cfg_nsam,
    // Sample input per carrier
    input wire logic [NUM_AC-1:0] i_smp_valid,
    input wire logic [NUM_AC-1:0][ICM_SMP_W-1:0] i_smp_i,
    input wire logic [NUM_AC-1:0][ICM_SMP_W-1:0] i_smp_q,
    output logic [NUM_AC-1:0] o_smp_ready,
    // Bit stream out
    output logic o_bit,
    output logic o_bit_valid,
    output logic o_bit_ctrl,
    output logic o_bit_reserved,
    output logic o_bit_stuff,
    output logic [3:0] o_bit_word,
    output logic [ICM_BIT_W-1:0] o_bit_idx,
    // Status
    output logic [NUM_AC-1:0] o_cfg_err,
    output logic [NUM_AC-1:0] o_underrun,
    output logic o_overlap_err
);
    localparam logic [ICM_BIT_W-1:0] BIT_LAST = ICM_BIT_W'(WORD_BITS - 1);
    localparam logic [ICM_SLOT_W-1:0] T_L = ICM_SLOT_W'(WORD_BITS);

    // One clock domain; assertions pause while reset is low
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // Frame position of the next bit
    logic [3:0] word_q;
    logic [ICM_BIT_W-1:0] bidx_q;
    logic [ICM_SLOT_W-1:0] iq_pos_q;                    // Bit offset inside the IQ block
    wire ctrl_w = (word_q == ICM_CTRL_WORD);             // Control word carries no IQ [R24]
    wire word_end_w = (bidx_q == BIT_LAST);

    // Position counters; a frame start realigns and emits nothing that cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_bf_start) begin
            word_q <= ICM_CTRL_WORD;
            bidx_q <= '0;
            iq_pos_q <= '0;
        end else if (i_bit_en) begin
            bidx_q <= word_end_w ? '0 : bidx_q + 1'b1;
            if (word_end_w) begin
                word_q <= (word_q == ICM_LAST_WORD) ? ICM_CTRL_WORD : word_q + 4'h1; // 16 words [R24]
            end
            if (!ctrl_w) begin
                iq_pos_q <= iq_pos_q + 1'b1;
            end else begin
                iq_pos_q <= '0;
            end
        end
    end

    // Shared per-carrier wires
    logic [NUM_AC-1:0] hit_w;
    logic [NUM_AC-1:0] stuff_w;
    logic [NUM_AC-1:0] val_w;
    logic [NUM_AC-1:0] ok_q;
    logic [NUM_AC-1:0][ICM_SLOT_W-1:0] slot_q;
    logic [ICM_SLOT_W-1:0] pstart_w [NUM_AC+1];          // Packed start offsets
    logic [NUM_AC-1:0][ICM_BLK_W-1:0] blk_mon_w;
    assign pstart_w[0] = '0;
    wire [NUM_AC-1:0] active_w = i_ac_en & ok_q;
    wire adv_en_w = i_bit_en && !i_bf_start && !ctrl_w;

    genvar c;
    generate
        for (c = 0; c < NUM_AC; c++) begin : g_ac
            // Configuration derived at load time
            wire ul_w = i_cfg_ul[c];                       // Direction picked per carrier [R6]
            wire [ICM_MW_W-1:0] m_w = i_cfg_width[c];     // Width of the loaded direction [R16]
            wire [ICM_BLK_W-1:0] k_w = ICM_BLK_W'(i_cfg_k[c]);      // S and K arrive worked out [R14]
            wire [ICM_BLK_W-1:0] s_w = ICM_BLK_W'(i_cfg_s[c]);
            wire [ICM_BLK_W-1:0] two_m_w = ICM_BLK_W'({m_w, 1'b0});
            wire [ICM_BLK_W-1:0] blk_len_w = ICM_BLK_W'(k_w * ICM_BLK_W'(i_cfg_slot[c]));
            wire [ICM_BLK_W-1:0] smp_bits_w = ICM_BLK_W'(s_w * two_m_w);
            wire [ICM_BLK_W-1:0] spare_w = blk_len_w - smp_bits_w;         // Block stuffing [R15]
            wire [ICM_BLK_W-1:0] nsym_w = ICM_BLK_W'(i_cfg_nsym[c]);
            wire [ICM_BLK_W-1:0] sym_stuff_w = (nsym_w == '0) ? '0 : spare_w / nsym_w; // [R21]
            wire [ICM_BLK_W-1:0] sam_bits_w = ICM_BLK_W'(ICM_BLK_W'(i_cfg_nsam[c]) * two_m_w);
            // Least slot for a block of S samples over K frames [R13] [R20]
            wire [ICM_BLK_W-1:0] ms_w = ICM_BLK_W'(ICM_BLK_W'(m_w) * s_w);
            wire [ICM_BLK_W-1:0] need_w = (k_w == '0) ? '0 : ICM_BLK_W'(((ms_w + k_w - 1'b1) / k_w) << 1);
            wire [ICM_BLK_W-1:0] slot_w = ICM_BLK_W'(i_cfg_slot[c]);
            wire [ICM_BLK_W-1:0] ovs_w = ICM_BLK_W'(i_cfg_ovs[c]);
            wire [ICM_SLOT_W-1:0] fstart_w = ICM_SLOT_W'((ICM_SLOT_W'(i_cfg_word[c]) - 1'b1) * T_L)
                + ICM_SLOT_W'(i_cfg_bit[c]);
            // Configuration checks
            wire odd_err_w = i_cfg_slot[c][0];                                              // [R1]
            wire wid_err_w = (m_w > ICM_MAX_W) || (m_w < (ul_w ? ICM_UL_MIN_W : ICM_DL_MIN_W)); // [R23]
            wire ovs_ok_w = ul_w ? (i_cfg_ovs[c] == ICM_UL_OVS_A || i_cfg_ovs[c] == ICM_UL_OVS_B) // [R4]
                : (i_cfg_ovs[c] == ICM_DL_OVS_A || i_cfg_ovs[c] == ICM_DL_OVS_B);         // [R5]
            wire chip_err_w = !ovs_ok_w || slot_w != ICM_BLK_W'(two_m_w * ovs_w);          // [R3]
            wire sk_err_w = (k_w == '0) || (s_w == '0);                                    // [R12]
            wire m1_err_w = sk_err_w || slot_w != need_w;                                  // [R13]
            wire m2_err_w = sk_err_w || slot_w < need_w || nsym_w == '0
                || ICM_BLK_W'(nsym_w * ICM_BLK_W'(i_cfg_nsam[c])) != s_w;                 // [R19] [R20]
            wire bc_err_w = slot_w != two_m_w;
            // Standard against method [R22]
            wire std_err_w = (i_cfg_std[c] == ICM_STD_CHIP) ? (i_cfg_method[c] != ICM_METH_CHIP)
                : (i_cfg_std[c] == ICM_STD_OFDM) ? (i_cfg_method[c] != ICM_METH_SMP && i_cfg_method[c] != ICM_METH_BC)
                : (i_cfg_std[c] == ICM_STD_SYMF) ? (i_cfg_method[c] == ICM_METH_CHIP) : 1'b1;
            wire meth_err_w = (i_cfg_method[c] == ICM_METH_CHIP) ? chip_err_w
                : (i_cfg_method[c] == ICM_METH_SMP) ? m1_err_w
                : (i_cfg_method[c] == ICM_METH_SYM) ? m2_err_w : bc_err_w;
            // Flexible address must sit in the IQ block on an even bit [R9]
            wire flex_err_w = !i_packed && (i_cfg_word[c] == ICM_CTRL_WORD || i_cfg_bit[c][0]
                || i_cfg_bit[c] > BIT_LAST);
            wire err_w = odd_err_w || wid_err_w || std_err_w || meth_err_w || flex_err_w;
            wire load_w = i_cfg_load[c] && !i_ac_en[c];    // Only an idle carrier reloads [R25]

            // Stored configuration
            logic [1:0] meth_q;
            logic [ICM_MW_W-1:0] m_q;
            logic [ICM_SLOT_W-1:0] fst_q;
            logic [ICM_BLK_W-1:0] blk_len_q, nst_q, sam_bits_q, sym_len_q;
            logic [ICM_SYM_W-1:0] nsym_q;
            logic err_q;
            logic [ICM_SLOT_W-1:0] slt_q;                  // Own copies keep one driver per vector
            logic on_q;
            // Configuration store, written only while the carrier is idle
            always_ff @(posedge i_mclk) begin
                if (!i_rst_n) begin
                    meth_q <= ICM_METH_CHIP;
                    m_q <= '0;
                    slt_q <= '0;
                    fst_q <= '0;
                    blk_len_q <= ICM_RST_CNT;
                    nst_q <= ICM_RST_CNT;
                    sam_bits_q <= ICM_RST_CNT;
                    sym_len_q <= ICM_RST_CNT;
                    nsym_q <= '0;
                    err_q <= 1'b0;
                    on_q <= 1'b0;
                end else if (load_w) begin                                                   // [R25]
                    meth_q <= i_cfg_method[c];
                    m_q <= m_w;
                    slt_q <= i_cfg_slot[c];
                    fst_q <= fstart_w;
                    blk_len_q <= blk_len_w;
                    nst_q <= spare_w;
                    sam_bits_q <= sam_bits_w;
                    sym_len_q <= sam_bits_w + sym_stuff_w;
                    nsym_q <= i_cfg_nsym[c];
                    err_q <= err_w;
                    on_q <= !err_w;
                end
            end
            assign o_cfg_err[c] = err_q;
            assign slot_q[c] = slt_q;
            assign ok_q[c] = on_q;

            // Slot placement: packed chain or stored flexible start [R8] [R9]
            wire [ICM_SLOT_W-1:0] start_w = i_packed ? pstart_w[c] : fst_q;
            assign pstart_w[c+1] = pstart_w[c] + (active_w[c] ? slot_q[c] : '0);           // [R8]
            assign hit_w[c] = active_w[c] && !ctrl_w && iq_pos_q >= start_w
                && iq_pos_q < start_w + slot_q[c];                                           // [R7]

            // Stream counters inside the slot block
            logic [ICM_BLK_W-1:0] blk_q, seg_q;
            logic [ICM_SYM_W-1:0] symn_q;
            logic [5:0] sbit_q;
            logic [ICM_SMP_W-1:0] si_q, sq_q;
            logic full_q, urun_q;
            wire is_m1_w = (meth_q == ICM_METH_SMP);
            wire is_m2_w = (meth_q == ICM_METH_SYM);
            // Stuffing precedes samples in method 1 [R15]; symbol then frame stuffing in method 2 [R18]
            assign stuff_w[c] = is_m1_w ? (blk_q < nst_q)
                : is_m2_w ? (symn_q >= nsym_q || seg_q >= sam_bits_q) : 1'b0;               // [R19]
            wire adv_w = adv_en_w && hit_w[c];
            wire blk_end_w = (blk_q == blk_len_q - 1'b1);
            wire seg_end_w = (seg_q == sym_len_q - 1'b1);
            wire [5:0] smp_last_w = 6'({m_q, 1'b0} - 1'b1);
            wire take_w = adv_w && !stuff_w[c];
            wire consume_w = take_w && (sbit_q == smp_last_w);
            // I then Q of each bit position, LSB first [R2]
            wire [4:0] half_w = sbit_q[5:1];
            assign val_w[c] = stuff_w[c] ? 1'b0 : (sbit_q[0] ? sq_q[half_w] : si_q[half_w]);
            // Refill in the cycle that drains the last bit, so back-to-back samples never starve [R2]
            wire room_w = !full_q || consume_w;
            assign o_smp_ready[c] = room_w;
            assign blk_mon_w[c] = blk_q;

            // Slot block walk: one continuous bit pipe over K frames [R11]
            always_ff @(posedge i_mclk) begin
                if (!i_rst_n || load_w || (i_radio_frame && is_m2_w)) begin                    // [R17]
                    blk_q <= ICM_RST_CNT;
                    seg_q <= ICM_RST_CNT;
                    symn_q <= '0;
                end else if (adv_w && (is_m1_w || is_m2_w)) begin
                    blk_q <= blk_end_w ? '0 : blk_q + 1'b1;                                    // [R11]
                    if (blk_end_w) begin
                        seg_q <= '0;
                        symn_q <= '0;
                    end else if (is_m2_w && symn_q < nsym_q) begin
                        seg_q <= seg_end_w ? '0 : seg_q + 1'b1;                                // [R21]
                        symn_q <= seg_end_w ? symn_q + 1'b1 : symn_q;                          // [R18]
                    end
                end
            end

            // Sample holding register, one sample ahead of the slot
            always_ff @(posedge i_mclk) begin
                if (!i_rst_n) begin
                    si_q <= ICM_RST_SMP;
                    sq_q <= ICM_RST_SMP;
                    full_q <= 1'b0;
                    sbit_q <= '0;
                    urun_q <= 1'b0;
                end else begin
                    if (i_smp_valid[c] && room_w) begin
                        si_q <= i_smp_i[c];
                        sq_q <= i_smp_q[c];
                        full_q <= 1'b1;
                    end else if (consume_w) begin
                        full_q <= 1'b0;
                    end
                    if (load_w) begin
                        sbit_q <= '0;
                    end else if (take_w) begin
                        sbit_q <= consume_w ? '0 : sbit_q + 1'b1;                              // [R2]
                    end
                    // Starved slot bit; the new event wins over the clear by load
                    if (take_w && !full_q) begin
                        urun_q <= 1'b1;
                    end else if (load_w) begin
                        urun_q <= 1'b0;
                    end
                end
            end
            assign o_underrun[c] = urun_q;

            // Assertions for this carrier
            sequence s_last_bit;
                take_w && sbit_q == smp_last_w;
            endsequence
            sample_wrap_a: assert property (s_last_bit |=> sbit_q == 6'h00) // [R2]
                else $error("sample bit index did not wrap after last bit");
            idle_load_a: assert property (i_cfg_load[c] && i_ac_en[c] |=> $stable(slot_q[c])) // [R25]
                else $error("configuration changed while carrier active");
            block_wrap_a: assert property (adv_w && is_m1_w && blk_end_w |=> blk_q == ICM_RST_CNT) // [R11]
                else $error("slot block did not restart");
            stuff_first_a: assert property (is_m1_w && blk_q == ICM_RST_CNT && nst_q != '0 |-> stuff_w[c]) // [R15]
                else $error("method 1 block did not open with stuffing");
            frame_align_a: assert property (i_radio_frame && is_m2_w |=> blk_q == ICM_RST_CNT && symn_q == '0) // [R17]
                else $error("method 2 block not aligned to radio frame");
            frame_stuff_a: assert property (is_m2_w && symn_q >= nsym_q |-> stuff_w[c] && val_w[c] == 1'b0) // [R18]
                else $error("frame stuffing carried sample bits");
            if (c + 1 < NUM_AC) begin : g_pk
                packed_order_a: assert property (i_packed && active_w[c] |-> pstart_w[c+1] == pstart_w[c] + slot_q[c]) // [R8]
                    else $error("packed slots not back to back");
            end
        end
    endgenerate

    // Lowest carrier wins a shared bit; overlap is flagged
    wire [NUM_AC-1:0] grant_w = hit_w & (~hit_w + 1'b1);
    wire multi_w = (hit_w & (hit_w - 1'b1)) != '0;
    wire sel_bit_w = |(grant_w & val_w);
    wire sel_stuff_w = |(grant_w & stuff_w);
    wire emit_w = i_bit_en && !i_bf_start;

    // Output bit registers; reserved bits go out as zero [R10]
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_bit <= 1'b0;
            o_bit_valid <= 1'b0;
            o_bit_ctrl <= 1'b0;
            o_bit_reserved <= 1'b0;
            o_bit_stuff <= 1'b0;
            o_bit_word <= ICM_CTRL_WORD;
            o_bit_idx <= '0;
            o_overlap_err <= 1'b0;
        end else begin
            o_bit_valid <= emit_w;
            if (emit_w) begin
                o_bit <= ctrl_w ? 1'b0 : sel_bit_w;
                o_bit_ctrl <= ctrl_w;                                                          // [R24]
                o_bit_reserved <= !ctrl_w && (hit_w == '0);                                    // [R10]
                o_bit_stuff <= !ctrl_w && sel_stuff_w;
                o_bit_word <= word_q;
                o_bit_idx <= bidx_q;
                // Sticky overlap until reset
                if (multi_w) begin
                    o_overlap_err <= 1'b1;                                                     // [R7]
                end
            end
        end
    end

    // Top level assertions
    ctrl_word_a: assert property (o_bit_valid && o_bit_ctrl |-> o_bit_word == ICM_CTRL_WORD && !o_bit_reserved) // [R24]
        else $error("control flag outside word 0");
    reserved_zero_a: assert property (o_bit_valid && o_bit_reserved |-> o_bit == 1'b0 && !o_bit_stuff) // [R10]
        else $error("reserved bit not zero");
    overlap_flag_a: assert property (emit_w && !ctrl_w && multi_w |=> o_overlap_err) // [R7]
        else $error("slot overlap not flagged");
endmodule : icm_mapper

// file: verification/icm_frame_rx.sv
// Far-side model that receives the basic frame bit stream from the mapper
module icm_frame_rx #(
    parameter int WORD_BITS = 8                          // Word length, matches the mapper
) (
    input wire logic i_mclk,
    input wire logic i_bit,
    input wire logic i_bit_valid,
    input wire logic i_bit_ctrl,
    input wire logic i_bit_reserved,
    input wire logic i_bit_stuff,
    input wire logic [3:0] i_bit_word,
    input wire logic [6:0] i_bit_idx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rx_bit [0:16*WORD_BITS-1];                     // Bits by frame position
    logic rx_res [0:16*WORD_BITS-1];                     // Reserved flag by position
    logic rx_ctl [0:16*WORD_BITS-1];                     // Control flag by position
    logic rx_stf [0:16*WORD_BITS-1];                     // Stuffing flag by position
    // Capture each emitted bit at its word and index, together with its reserved, control and stuffing flags
    always @(posedge i_mclk) begin
        if (i_bit_valid === 1'b1) begin
            rx_bit[i_bit_word*WORD_BITS+i_bit_idx] <= i_bit;
            rx_res[i_bit_word*WORD_BITS+i_bit_idx] <= i_bit_reserved;
            rx_ctl[i_bit_word*WORD_BITS+i_bit_idx] <= i_bit_ctrl;
            rx_stf[i_bit_word*WORD_BITS+i_bit_idx] <= i_bit_stuff;
        end
    end
endmodule : icm_frame_rx

// file: verification/test_icm_mapper.sv
// Self-checking bench for the carrier slot mapper
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module test_icm_mapper;
    import icm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WB = 8;                               // Short words keep the frame brief
    logic i_mclk = 0, i_rst_n = 0, i_bit_en = 0, i_bf_start = 0, i_radio_frame = 0, i_packed = 1;
    logic [3:0] i_ac_en = 0, i_cfg_load = 0, i_cfg_ul = 0, i_smp_valid = 0, o_smp_ready, o_cfg_err, o_underrun;
    logic [3:0][1:0] i_cfg_std = 0, i_cfg_method = 0;
    logic [3:0][4:0] i_cfg_width = 0;
    logic [3:0][2:0] i_cfg_ovs = 0;
    logic [3:0][15:0] i_cfg_s = {4{16'h0001}}, i_cfg_k = {4{16'h0001}};
    logic [3:0][11:0] i_cfg_slot = 0, i_cfg_nsam = 0;
    logic [3:0][3:0] i_cfg_word = 0;
    logic [3:0][6:0] i_cfg_bit = 0;
    logic [3:0][7:0] i_cfg_nsym = 0;
    logic [3:0][19:0] i_smp_i = 0, i_smp_q = 0;
    logic o_bit, o_bit_valid, o_bit_ctrl, o_bit_reserved, o_bit_stuff, o_overlap_err;
    logic [3:0] o_bit_word;
    logic [6:0] o_bit_idx;
    int bad_count = 0, n_tests = 0;
    always #50 i_mclk = ~i_mclk;                         // 10 MHz
    icm_mapper #(.NUM_AC(4), .WORD_BITS(WB)) u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bit_en(i_bit_en),
        .i_bf_start(i_bf_start), .i_radio_frame(i_radio_frame), .i_packed(i_packed), .i_ac_en(i_ac_en),
        .i_cfg_load(i_cfg_load), .i_cfg_ul(i_cfg_ul), .i_cfg_std(i_cfg_std), .i_cfg_method(i_cfg_method),
        .i_cfg_width(i_cfg_width), .i_cfg_ovs(i_cfg_ovs), .i_cfg_s(i_cfg_s), .i_cfg_k(i_cfg_k),
        .i_cfg_slot(i_cfg_slot), .i_cfg_word(i_cfg_word), .i_cfg_bit(i_cfg_bit), .i_cfg_nsym(i_cfg_nsym),
        .i_cfg_nsam(i_cfg_nsam), .i_smp_valid(i_smp_valid), .i_smp_i(i_smp_i), .i_smp_q(i_smp_q),
        .o_smp_ready(o_smp_ready), .o_bit(o_bit), .o_bit_valid(o_bit_valid), .o_bit_ctrl(o_bit_ctrl),
        .o_bit_reserved(o_bit_reserved), .o_bit_stuff(o_bit_stuff), .o_bit_word(o_bit_word),
        .o_bit_idx(o_bit_idx), .o_cfg_err(o_cfg_err), .o_underrun(o_underrun), .o_overlap_err(o_overlap_err));
    icm_frame_rx #(.WORD_BITS(WB)) u_rx (.i_mclk(i_mclk), .i_bit(o_bit), .i_bit_valid(o_bit_valid),
        .i_bit_ctrl(o_bit_ctrl), .i_bit_reserved(o_bit_reserved), .i_bit_stuff(o_bit_stuff),
        .i_bit_word(o_bit_word), .i_bit_idx(o_bit_idx));
    // Verdict in one place
    task automatic wrap_up();
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Load carrier 0 and return its error flag one cycle later
    task automatic load0(input logic ul, input logic [1:0] std, input logic [1:0] meth, input logic [4:0] w,
                         input logic [2:0] ovs, input logic [11:0] slot, output logic err);
        @(posedge i_mclk);
        i_cfg_ul[0] <= ul;
        i_cfg_std[0] <= std;
        i_cfg_method[0] <= meth;
        i_cfg_width[0] <= w;
        i_cfg_ovs[0] <= ovs;
        i_cfg_slot[0] <= slot;
        i_cfg_load[0] <= 1'b1;
        @(posedge i_mclk);
        i_cfg_load[0] <= 1'b0;
        @(posedge i_mclk);
        err = o_cfg_err[0];
    endtask : load0
    // One realigned basic frame of bits, then a few idle cycles
    task automatic run_frame();
        i_bf_start <= 1'b1;
        @(posedge i_mclk);
        i_bf_start <= 1'b0;
        i_bit_en <= 1'b1;
        repeat (16 * WB) @(posedge i_mclk);
        i_bit_en <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask : run_frame
    // Cut a hang short
    initial begin
        repeat (3000) @(posedge i_mclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        logic e;
        logic [19:0] si, sq;
        si = 20'h000a5;
        sq = 20'h0003c;
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        `CHK(o_smp_ready, 4'hf)
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h1, 12'h011, e); `CHK(e, 1'b1)
        load0(1'b0, 2'h0, 2'h0, 5'h07, 3'h1, 12'h00e, e); `CHK(e, 1'b1)
        load0(1'b1, 2'h0, 2'h0, 5'h04, 3'h2, 12'h010, e); `CHK(e, 1'b0)
        load0(1'b1, 2'h0, 2'h0, 5'h04, 3'h1, 12'h008, e); `CHK(e, 1'b1)
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h2, 12'h020, e); `CHK(e, 1'b0)
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h4, 12'h040, e); `CHK(e, 1'b1)
        load0(1'b0, 2'h1, 2'h2, 5'h08, 3'h1, 12'h010, e); `CHK(e, 1'b1)
        load0(1'b0, 2'h1, 2'h1, 5'h08, 3'h1, 12'h010, e); `CHK(e, 1'b0)
        i_packed <= 1'b0;
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h1, 12'h010, e); `CHK(e, 1'b1)
        i_cfg_word[0] <= 4'h1;
        i_cfg_bit[0] <= 7'h02;
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h1, 12'h010, e); `CHK(e, 1'b0)
        i_packed <= 1'b1;
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h1, 12'h010, e); `CHK(e, 1'b0)
        i_ac_en[0] <= 1'b1;
        load0(1'b0, 2'h0, 2'h0, 5'h08, 3'h1, 12'h011, e); `CHK(e, 1'b0)
        i_smp_i[0] <= si;
        i_smp_q[0] <= sq;
        i_smp_valid[0] <= 1'b1;
        @(posedge i_mclk);
        i_smp_valid[0] <= 1'b0;
        run_frame();
        `CHK(o_smp_ready[0], 1'b1)
        for (int p = 0; p < WB; p++) `CHK(u_rx.rx_ctl[p], 1'b1)
        for (int p = 0; p < 16; p++) `CHK(u_rx.rx_bit[WB+p], p[0] ? sq[p>>1] : si[p>>1])
        for (int p = 0; p < 16; p++) `CHK(u_rx.rx_res[WB+p], 1'b0)
        for (int p = WB + 16; p < 16 * WB; p++) `CHK(u_rx.rx_res[p], 1'b1)
        for (int p = 0; p < 16; p++) `CHK(u_rx.rx_stf[WB+p], 1'b0)
        // No sample offered: the next slot starves
        run_frame();
        `CHK(o_underrun[0], 1'b1)
        // Method 1 with S=2, K=3: 12-bit slot, 4 stuffing bits lead each 36-bit block
        i_ac_en[0] <= 1'b0;
        i_cfg_s[0] <= 16'h0002;
        i_cfg_k[0] <= 16'h0003;
        i_smp_valid[0] <= 1'b1;
        load0(1'b0, 2'h1, 2'h1, 5'h08, 3'h1, 12'h00c, e); `CHK(e, 1'b0)
        `CHK(o_underrun[0], 1'b0)
        i_ac_en[0] <= 1'b1;
        run_frame();
        for (int p = 0; p < 4; p++) `CHK(u_rx.rx_stf[WB+p], 1'b1)
        for (int p = 0; p < 8; p++) `CHK(u_rx.rx_bit[WB+4+p], p[0] ? sq[p>>1] : si[p>>1])
        run_frame();
        run_frame();
        // Third frame closes the block with bits 4..15 of the second sample
        for (int p = 0; p < 12; p++) `CHK(u_rx.rx_bit[WB+p], p[0] ? sq[(p+4)>>1] : si[(p+4)>>1])
        `CHK(o_underrun[0], 1'b0)
        `CHK(o_overlap_err, 1'b0)
        wrap_up();
    end
endmodule : test_icm_mapper
